// ---- sar_adc_pkg.sv ----
// Constants, types and field layout of the converter digital control
// Functional notes
// - Analog pins readable as 8-bit digital input port
// - Output port latched in upper port byte
// - Thirty-two word map with results and reserved
// - Base FF700 in bank 7 or F
// - Buffered registers immediate; control writes abort conversion
// - Slave only; every bus cycle terminated
// - Stop gates converter clock, aborts, registers accessible
// - Reset sets stop; software clears, waits recovery
// - Freeze field: ignore, finish then freeze, immediate
// - Frozen holds all activity, registers stay valid
// - After freeze, sequence continues at next step
// - Four-bit channel selects pins or references
// - Two clocks capacitor, two clocks amplifier drive
// - Direct sample phase 2, 4, 8, 16 clocks
// - Approximation bits resolved MSB first by comparator
// - Finished approximation copied to result registers
// - Timing register write aborts and halts converter
// - Sequence register write aborts and restarts sequence
// - Prescaler modulus n then halve: divide 2(n+1), n of zero taken as one
// - Prescaler field resets to three, divide eight
// - At least four bus clocks per converter clock
// - Resolution bit selects 8 or 10, auto-aligned
package sar_adc_pkg;

   // Bus address decode: bank digit, fixed middle bits, word index
   localparam logic [3:0] BANK_LOW = 4'h7;
   localparam logic [3:0] BANK_HIGH = 4'hf;
   localparam logic [13:0] BASE_MID = 14'h3fdc;

   // Word indices inside the 32-word window
   localparam logic [4:0] OFS_CONFIG = 5'h00;
   localparam logic [4:0] OFS_TEST = 5'h01;
   localparam logic [4:0] OFS_PORT = 5'h03;
   localparam logic [4:0] OFS_TIMING = 5'h05;
   localparam logic [4:0] OFS_SEQ = 5'h06;
   localparam logic [4:0] OFS_STATUS = 5'h07;
   localparam logic [1:0] FMT_RIGHT = 2'h1;
   localparam logic [1:0] FMT_LEFT_SIGNED = 2'h2;
   localparam logic [1:0] FMT_LEFT_UNSIGNED = 2'h3;

   // Field positions
   localparam int CFG_STOP_BIT = 15;
   localparam int CFG_FRZ_LSB = 13;
   localparam int TIM_TEN_BIT_RESOLUTION_SELECT_BIT = 7;
   localparam int TIM_STS_LSB = 5;
   localparam int SEQ_SCAN_BIT = 6;
   localparam int SEQ_MULT_BIT = 5;
   localparam int SEQ_S8CM_BIT = 4;

   // Values after reset
   localparam logic [15:0] CONFIG_RST = 16'h8000;
   localparam logic [7:0] TIMING_RST = 8'h03;
   localparam logic [7:0] SEQ_RST = 8'h00;
   localparam logic [15:0] TEST_RST = 16'h0000;
   localparam logic [7:0] PORT_OUT_RST = 8'h00;

   // Freeze response codes
   localparam logic [1:0] FRZ_IGNORE = 2'h0;
   localparam logic [1:0] FRZ_FINISH = 2'h2;
   localparam logic [1:0] FRZ_NOW = 2'h3;

   // Sequence timing in converter clocks
   localparam logic [4:0] SAMPLE_PHASE_CLKS = 5'h02;
   localparam logic [4:0] MIN_PRESCALE = 5'h01;
   localparam logic [3:0] MSB_INDEX = 4'h9;
   localparam logic [3:0] LSB_TEN = 4'h0;
   localparam logic [3:0] LSB_EIGHT = 4'h2;
   localparam logic [2:0] LAST_OF_FOUR = 3'h3;
   localparam logic [2:0] LAST_OF_EIGHT = 3'h7;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_SAMP_CAP = 6'h02,
      ST_SAMP_AMP = 6'h04,
      ST_SAMP_DIRECT = 6'h08,
      ST_RESOLVE = 6'h10,
      ST_STORE = 6'h20
   } seq_state_t;

   // Drive toward the analog front end
   typedef struct packed {
      logic conv_clk;
      logic [3:0] channel;
      logic cap_connect;
      logic amp_drive;
      logic direct_connect;
      logic [9:0] dac_code;
   } analog_ctrl_t;

endpackage

// ---- sar_adc_ctrl.sv ----
// Digital control of the successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
module sar_adc_ctrl #(
   parameter int ADDR_W = 24,
   parameter int PORT_W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [15:0] bus_rdata,
   input wire logic module_map_select,
   input wire logic freeze,
   input wire logic comparator_high,
   input wire logic [PORT_W-1:0] digital_in_port_bits,
   output logic [PORT_W-1:0] digital_out_port_bits,
   output var sar_adc_pkg::analog_ctrl_t analog_ctrl,
   output logic conv_busy
);

   // Decode below assumes a 24-bit bus and an 8-bit port
   if (ADDR_W != 24 || PORT_W != 8) begin : g_bad_params
      $error("sar_adc_ctrl supports ADDR_W 24 and PORT_W 8 only");
   end

   // Phase counter and trial index widths fix these constants
   if (sar_adc_pkg::SAMPLE_PHASE_CLKS == 5'h00 ||
       sar_adc_pkg::MSB_INDEX != 4'h9) begin : g_bad_consts
      $error("sar_adc_ctrl phase or index constants out of range");
   end

   // Result view in one of the three formats
   function automatic logic [15:0] fmt_result(input logic [1:0] fmt,
         input logic [9:0] sar, input logic ten);
      logic [15:0] r;
      r = 16'h0000;
      case (fmt)
         sar_adc_pkg::FMT_RIGHT:
            r = ten ? {6'h00, sar} : {8'h00, sar[9:2]};
         sar_adc_pkg::FMT_LEFT_SIGNED:
            r = ten ? {~sar[9], sar[8:0], 6'h00}
                    : {~sar[9], sar[8:2], 8'h00};
         sar_adc_pkg::FMT_LEFT_UNSIGNED:
            r = ten ? {sar, 6'h00} : {sar[9:2], 8'h00};
         default:
            r = 16'h0000;
      endcase
      return r;
   endfunction

   // Word decode on a mapped cycle; every write enable uses it
   function automatic logic word_sel(input logic strobe,
         input logic in_window, input logic [4:0] idx,
         input logic [4:0] want);
      return strobe && in_window && idx == want;
   endfunction

   logic [15:0] config_q;
   logic [15:0] test_q;
   logic [7:0] port_out_q;
   logic [7:0] timing_q;
   logic [7:0] seq_q;
   logic [7:0] port_in_meta_q;
   logic [7:0] port_in_q;
   logic comp_meta_q;
   logic comp_q;
   logic [4:0] pre_cnt_q;
   logic conv_clk_q;
   logic tick_q;
   sar_adc_pkg::seq_state_t state_q;
   logic [4:0] phase_q;
   logic [3:0] bit_idx_q;
   logic [2:0] conv_idx_q;
   logic [9:0] sar_q;
   logic scf_q;
   logic [7:0] ccf_q;
   logic [9:0] result_q [8];

   logic hit;
   logic [4:0] widx;
   logic wr_timing;
   logic wr_seq;
   logic wr_config;
   logic wr_test;
   logic wr_port;
   logic step;
   logic store_now;
   logic stop;
   logic [1:0] frz;
   logic mid_conv;
   logic frozen;
   logic [4:0] prs_eff;
   logic [4:0] direct_len;
   logic [3:0] lsb_idx;
   logic [2:0] last_idx;
   logic [3:0] conv_channel;

   // Module window at FF700 in bank 7 or F, word index from bits 5:1
   assign hit = (bus_addr[23:20] == (module_map_select ?
                  sar_adc_pkg::BANK_HIGH : sar_adc_pkg::BANK_LOW)) &&
                (bus_addr[19:6] == sar_adc_pkg::BASE_MID);
   assign widx = bus_addr[5:1];
   assign wr_config = word_sel(bus_wr, hit, widx, sar_adc_pkg::OFS_CONFIG);
   assign wr_test = word_sel(bus_wr, hit, widx, sar_adc_pkg::OFS_TEST);
   assign wr_port = word_sel(bus_wr, hit, widx, sar_adc_pkg::OFS_PORT);
   assign wr_timing = word_sel(bus_wr, hit, widx, sar_adc_pkg::OFS_TIMING);
   assign wr_seq = word_sel(bus_wr, hit, widx, sar_adc_pkg::OFS_SEQ);

   // Mode decode
   assign stop = config_q[sar_adc_pkg::CFG_STOP_BIT];
   assign frz = config_q[sar_adc_pkg::CFG_FRZ_LSB +: 2];
   assign prs_eff = (timing_q[4:0] == 5'h00) ?
                    sar_adc_pkg::MIN_PRESCALE : timing_q[4:0];
   assign direct_len = 5'h02 << timing_q[sar_adc_pkg::TIM_STS_LSB +: 2];
   assign lsb_idx = timing_q[sar_adc_pkg::TIM_TEN_BIT_RESOLUTION_SELECT_BIT] ?
                    sar_adc_pkg::LSB_TEN : sar_adc_pkg::LSB_EIGHT;
   assign last_idx = seq_q[sar_adc_pkg::SEQ_S8CM_BIT] ?
                     sar_adc_pkg::LAST_OF_EIGHT : sar_adc_pkg::LAST_OF_FOUR;

   // Conversion boundary: idle, or first tick of a new sample period
   assign mid_conv = !(state_q == sar_adc_pkg::ST_IDLE ||
                       (state_q == sar_adc_pkg::ST_SAMP_CAP &&
                        phase_q == 5'h00));

   // Reserved code falls through as ignore, so it never stalls
   always_comb begin
      case (frz)
         sar_adc_pkg::FRZ_NOW: frozen = freeze;
         sar_adc_pkg::FRZ_FINISH: frozen = freeze && !mid_conv;
         default: frozen = 1'b0;
      endcase
   end

   // Freeze also blocks a tick already in flight; an abort in the
   // same cycle beats a store, so results never outlive the abort
   assign step = tick_q && !frozen;
   assign store_now = step && !stop && !wr_timing && !wr_seq &&
                      state_q == sar_adc_pkg::ST_STORE;

   // Channel: single source, or a block of four or eight from the base
   always_comb begin
      if (!seq_q[sar_adc_pkg::SEQ_MULT_BIT]) begin
         conv_channel = seq_q[3:0];
      end else if (seq_q[sar_adc_pkg::SEQ_S8CM_BIT]) begin
         conv_channel = {seq_q[3], conv_idx_q};
      end else begin
         conv_channel = {seq_q[3:2], conv_idx_q[1:0]};
      end
   end

   // Pin inputs pass two flops before anything reads them
   // Comparator lag is three clocks, inside the four-clock tick
   always_ff @(posedge core_clk) begin
      if (rst) begin
         port_in_meta_q <= 8'h00;
         port_in_q <= 8'h00;
         comp_meta_q <= 1'b0;
         comp_q <= 1'b0;
      end else begin
         port_in_meta_q <= digital_in_port_bits;
         port_in_q <= port_in_meta_q;
         comp_meta_q <= comparator_high;
         comp_q <= comp_meta_q;
      end
   end

   // Configuration register: stop and freeze response
   always_ff @(posedge core_clk) begin
      if (rst) begin
         config_q <= sar_adc_pkg::CONFIG_RST;
      end else if (wr_config) begin
         config_q <= {bus_wdata[15:13], 13'h0000};
      end
   end

   // Test register only stores; no test hooks in this logic
   always_ff @(posedge core_clk) begin
      if (rst) begin
         test_q <= sar_adc_pkg::TEST_RST;
      end else if (wr_test) begin
         test_q <= bus_wdata;
      end
   end

   // Output port latch in the upper byte of the port word
   always_ff @(posedge core_clk) begin
      if (rst) begin
         port_out_q <= sar_adc_pkg::PORT_OUT_RST;
      end else if (wr_port) begin
         port_out_q <= bus_wdata[15:8];
      end
   end

   // Control registers
   always_ff @(posedge core_clk) begin
      if (rst) begin
         timing_q <= sar_adc_pkg::TIMING_RST;
         seq_q <= sar_adc_pkg::SEQ_RST;
      end else begin
         if (wr_timing) begin
            timing_q <= bus_wdata[7:0];
         end
         if (wr_seq) begin
            seq_q <= {1'b0, bus_wdata[6:0]};
         end
      end
   end

   // Prescaler: modulus count then halve; tick on each rising half
   // Stop clears it, freeze only holds it so the phase is kept
   // A smaller divider written mid-half wraps at once, never below two
   always_ff @(posedge core_clk) begin
      if (rst || stop) begin
         pre_cnt_q <= 5'h00;
         conv_clk_q <= 1'b0;
         tick_q <= 1'b0;
      end else if (frozen) begin
         tick_q <= 1'b0;
      end else if (pre_cnt_q >= prs_eff) begin
         pre_cnt_q <= 5'h00;
         conv_clk_q <= !conv_clk_q;
         tick_q <= !conv_clk_q;
      end else begin
         pre_cnt_q <= pre_cnt_q + 5'h01;
         tick_q <= 1'b0;
      end
   end

   // Sequencer: sample phases, resolution, store
   // Software must allow analog recovery after stop clears
   always_ff @(posedge core_clk) begin
      if (rst || stop) begin
         state_q <= sar_adc_pkg::ST_IDLE;
         phase_q <= 5'h00;
         bit_idx_q <= 4'h0;
         conv_idx_q <= 3'h0;
         sar_q <= 10'h000;
         scf_q <= 1'b0;
         ccf_q <= 8'h00;
      end else if (wr_timing || wr_seq) begin
         // Sequence write restarts; timing write leaves it halted
         state_q <= wr_seq ? sar_adc_pkg::ST_SAMP_CAP
                           : sar_adc_pkg::ST_IDLE;
         phase_q <= 5'h00;
         bit_idx_q <= 4'h0;
         conv_idx_q <= 3'h0;
         scf_q <= 1'b0;
         ccf_q <= 8'h00;
      end else if (step) begin
         // Ticks stop while frozen, so the next tick is the next step
         case (state_q)
            sar_adc_pkg::ST_SAMP_CAP: begin
               if (phase_q == sar_adc_pkg::SAMPLE_PHASE_CLKS - 5'h01) begin
                  state_q <= sar_adc_pkg::ST_SAMP_AMP;
                  phase_q <= 5'h00;
               end else begin
                  phase_q <= phase_q + 5'h01;
               end
            end
            sar_adc_pkg::ST_SAMP_AMP: begin
               if (phase_q == sar_adc_pkg::SAMPLE_PHASE_CLKS - 5'h01) begin
                  state_q <= sar_adc_pkg::ST_SAMP_DIRECT;
                  phase_q <= 5'h00;
               end else begin
                  phase_q <= phase_q + 5'h01;
               end
            end
            sar_adc_pkg::ST_SAMP_DIRECT: begin
               if (phase_q == direct_len - 5'h01) begin
                  state_q <= sar_adc_pkg::ST_RESOLVE;
                  phase_q <= 5'h00;
                  bit_idx_q <= sar_adc_pkg::MSB_INDEX;
                  sar_q <= 10'h200;
               end else begin
                  phase_q <= phase_q + 5'h01;
               end
            end
            sar_adc_pkg::ST_RESOLVE: begin
               // DAC above input clears the trial bit
               sar_q[bit_idx_q] <= !comp_q;
               if (bit_idx_q == lsb_idx) begin
                  state_q <= sar_adc_pkg::ST_STORE;
               end else begin
                  sar_q[bit_idx_q - 4'h1] <= 1'b1;
                  bit_idx_q <= bit_idx_q - 4'h1;
               end
            end
            sar_adc_pkg::ST_STORE: begin
               ccf_q[conv_idx_q] <= 1'b1;
               sar_q <= 10'h000;
               if (conv_idx_q == last_idx) begin
                  scf_q <= 1'b1;
                  conv_idx_q <= 3'h0;
                  state_q <= seq_q[sar_adc_pkg::SEQ_SCAN_BIT] ?
                             sar_adc_pkg::ST_SAMP_CAP : sar_adc_pkg::ST_IDLE;
               end else begin
                  conv_idx_q <= conv_idx_q + 3'h1;
                  state_q <= sar_adc_pkg::ST_SAMP_CAP;
               end
            end
            default: begin
               state_q <= sar_adc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Result storage; earlier results are overwritten when scanning
   always_ff @(posedge core_clk) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) begin
            result_q[i] <= 10'h000;
         end
      end else if (store_now) begin
         result_q[conv_idx_q] <= sar_q;
      end
   end

   // Drive toward the analog front end, registered
   always_ff @(posedge core_clk) begin
      if (rst) begin
         analog_ctrl <= '0;
         conv_busy <= 1'b0;
      end else begin
         analog_ctrl.conv_clk <= conv_clk_q;
         analog_ctrl.channel <= conv_channel;
         analog_ctrl.cap_connect <= state_q == sar_adc_pkg::ST_SAMP_CAP;
         analog_ctrl.amp_drive <= state_q == sar_adc_pkg::ST_SAMP_AMP;
         analog_ctrl.direct_connect <=
            state_q == sar_adc_pkg::ST_SAMP_DIRECT;
         analog_ctrl.dac_code <= sar_q;
         conv_busy <= state_q != sar_adc_pkg::ST_IDLE;
      end
   end

   // Output port pins follow the latch
   always_ff @(posedge core_clk) begin
      if (rst) begin
         digital_out_port_bits <= sar_adc_pkg::PORT_OUT_RST;
      end else begin
         digital_out_port_bits <= port_out_q;
      end
   end

   // Read data one cycle after the strobe; zero otherwise
   // Slave never waits, so every cycle ends in one clock
   always_ff @(posedge core_clk) begin
      if (rst) begin
         bus_rdata <= 16'h0000;
      end else if (bus_rd && hit) begin
         case (widx)
            sar_adc_pkg::OFS_CONFIG: bus_rdata <= config_q;
            sar_adc_pkg::OFS_TEST: bus_rdata <= test_q;
            sar_adc_pkg::OFS_PORT:
               bus_rdata <= {port_out_q, port_in_q};
            sar_adc_pkg::OFS_TIMING: bus_rdata <= {8'h00, timing_q};
            sar_adc_pkg::OFS_SEQ: bus_rdata <= {8'h00, seq_q};
            sar_adc_pkg::OFS_STATUS:
               bus_rdata <= {scf_q, 4'h0, conv_idx_q, ccf_q};
            default:
               bus_rdata <= fmt_result(widx[4:3], result_q[widx[2:0]],
                             timing_q[sar_adc_pkg::TIM_TEN_BIT_RESOLUTION_SELECT_BIT]);
         endcase
      end else begin
         bus_rdata <= 16'h0000;
      end
   end

endmodule
`default_nettype wire

// ---- sar_front_model.sv ----
// Behavioural comparator standing in for the analog front end
`timescale 1ns/1ps
`default_nettype none
module sar_front_model (
   input wire logic [9:0] level,
   input wire sar_adc_pkg::analog_ctrl_t ctrl,
   output logic comparator_high
);
   // Ideal compare; no droop while frozen, so results stay exact
   assign comparator_high = ctrl.dac_code > level;
endmodule
`default_nettype wire

// ---- sar_adc_ctrl_monitor.sv ----
// Port checker of the converter digital control
`timescale 1ns/1ps
`default_nettype none
module sar_adc_ctrl_monitor #(
   parameter int ADDR_W = 24,
   parameter int PORT_W = 8
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [15:0] bus_rdata,
   input wire logic module_map_select,
   input wire logic freeze,
   input wire logic comparator_high,
   input wire logic [PORT_W-1:0] digital_in_port_bits,
   input wire logic [PORT_W-1:0] digital_out_port_bits,
   input wire sar_adc_pkg::analog_ctrl_t analog_ctrl,
   input wire logic conv_busy
);
   logic hit;
   logic [4:0] idx;
   logic [4:0] prs_q;
   logic [1:0] sts_q;
   logic [7:0] seq_q;
   logic stop_q;
   logic [1:0] ph;
   logic [1:0] ph_q;
   logic clk_q;
   logic [9:0] run_q;
   logic [15:0] hc_q;
   int amp_n;
   int dir_n;
   // Address decode and expected phase lengths
   assign idx = bus_addr[5:1];
   assign hit = bus_addr[23:20] == (module_map_select ? 4'hf : 4'h7)
      && bus_addr[19:6] == sar_adc_pkg::BASE_MID;
   assign ph = {analog_ctrl.amp_drive, analog_ctrl.direct_connect};
   assign amp_n = 4 * (prs_q + 1);
   assign dir_n = (32'h2 << sts_q) * 2 * (prs_q + 1);
   // Shadow of the fields that shape timing
   always_ff @(posedge core_clk) begin
      if (rst) begin
         prs_q <= 5'h03;
         sts_q <= 2'h0;
         seq_q <= 8'h00;
         stop_q <= 1'h1;
      end else if (hit && bus_wr) begin
         if (idx == sar_adc_pkg::OFS_TIMING) begin
            prs_q <= bus_wdata[4:0];
            sts_q <= bus_wdata[6:5];
         end
         if (idx == sar_adc_pkg::OFS_SEQ)
            seq_q <= bus_wdata[7:0];
         if (idx == sar_adc_pkg::OFS_CONFIG)
            stop_q <= bus_wdata[15];
      end
   end
   // Run lengths; cleared in reset so no unknown reaches a compare
   always_ff @(posedge core_clk) begin
      ph_q <= ph;
      clk_q <= analog_ctrl.conv_clk;
      if (rst) begin
         run_q <= 10'h000;
         hc_q <= 16'h0000;
      end else begin
         run_q <= (ph != ph_q) ? 10'h001 : run_q + 10'h001;
         hc_q <= (clk_q != analog_ctrl.conv_clk) ? 16'h0001 : hc_q + 16'h0001;
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   rd_quiet_a: assert property (
      !$past(bus_rd) |-> bus_rdata == 16'h0000)
      else $error("read data not zero outside read answer");
   out_latch_a: assert property (
      hit && bus_wr && idx == sar_adc_pkg::OFS_PORT
      |-> ##2 digital_out_port_bits == $past(bus_wdata[15:8], 2))
      else $error("output port does not follow write");
   tim_halt_a: assert property (
      hit && bus_wr && idx == sar_adc_pkg::OFS_TIMING |-> ##2 !conv_busy)
      else $error("timing write did not halt");
   seq_start_a: assert property (
      hit && bus_wr && idx == sar_adc_pkg::OFS_SEQ && !stop_q && !freeze
      |-> ##[1:2] conv_busy)
      else $error("sequence write did not start");
   stop_abort_a: assert property (
      hit && bus_wr && idx == sar_adc_pkg::OFS_CONFIG && bus_wdata[15]
      |-> ##3 !conv_busy)
      else $error("stop did not abort");
   amp_len_a: assert property (
      ph_q[1] && !ph[1] && conv_busy |-> run_q == amp_n)
      else $error("amplifier phase length wrong");
   direct_len_a: assert property (
      ph_q[0] && !ph[0] && conv_busy |-> run_q == dir_n)
      else $error("direct phase length wrong");
   clk_ratio_a: assert property (
      clk_q != analog_ctrl.conv_clk && !stop_q |-> hc_q >= 2)
      else $error("converter clock half too short");
   chan_sel_a: assert property (
      analog_ctrl.cap_connect && !seq_q[5] && $stable(seq_q)
      |-> analog_ctrl.channel == seq_q[3:0])
      else $error("channel differs from selection");
   chan_block_a: assert property (
      analog_ctrl.cap_connect && seq_q[5] && !seq_q[4] && $stable(seq_q)
      |-> analog_ctrl.channel[3:2] == seq_q[3:2])
      else $error("channel outside selected block");
   dac_msb_a: assert property (
      $fell(analog_ctrl.direct_connect) && conv_busy
      |-> ##[0:1] analog_ctrl.dac_code == 10'h200)
      else $error("resolve does not open at top bit");
endmodule
bind sar_adc_ctrl sar_adc_ctrl_monitor #(
   .ADDR_W(ADDR_W),
   .PORT_W(PORT_W)
) sar_adc_ctrl_monitor_i (
   .core_clk(core_clk),
   .rst(rst),
   .bus_addr(bus_addr),
   .bus_wdata(bus_wdata),
   .bus_wr(bus_wr),
   .bus_rd(bus_rd),
   .bus_rdata(bus_rdata),
   .module_map_select(module_map_select),
   .freeze(freeze),
   .comparator_high(comparator_high),
   .digital_in_port_bits(digital_in_port_bits),
   .digital_out_port_bits(digital_out_port_bits),
   .analog_ctrl(analog_ctrl),
   .conv_busy(conv_busy)
);
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench of the converter digital control
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic core_clk = 1'h0;
   logic rst = 1'h1;
   logic [23:0] bus_addr = 24'h000000;
   logic [15:0] bus_wdata = 16'h0000;
   logic bus_wr = 1'h0;
   logic bus_rd = 1'h0;
   logic module_map_select = 1'h0;
   logic freeze = 1'h0;
   logic [7:0] pin_in = 8'h00;
   logic [9:0] level = 10'h000;
   logic [3:0] bk = 4'h7;
   logic [15:0] bus_rdata;
   logic [7:0] pin_out;
   logic comparator_high;
   logic conv_busy;
   sar_adc_pkg::analog_ctrl_t actl;
   int n_mismatch = 0;
   int check_count = 0;
   int seed = 59;
   always #50 core_clk = ~core_clk;
   sar_adc_ctrl sar_adc_ctrl_i (.core_clk(core_clk), .rst(rst),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
      .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .module_map_select(module_map_select), .freeze(freeze),
      .comparator_high(comparator_high), .digital_in_port_bits(pin_in),
      .digital_out_port_bits(pin_out), .analog_ctrl(actl),
      .conv_busy(conv_busy));
   sar_front_model sar_front_model_i (.level(level), .ctrl(actl),
      .comparator_high(comparator_high));
   task automatic end_of_test();
      if (n_mismatch == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
         input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // Bus cycles: strobe for one cycle, released at the sampling edge
   task automatic wr(input logic [4:0] i, input logic [15:0] v);
      @(posedge core_clk);
      bus_addr <= {bk, sar_adc_pkg::BASE_MID, i, 1'h0};
      bus_wdata <= v;
      bus_wr <= 1'h1;
      @(posedge core_clk);
      bus_wr <= 1'h0;
   endtask
   task automatic rd(input logic [4:0] i, output logic [15:0] v);
      @(posedge core_clk);
      bus_addr <= {bk, sar_adc_pkg::BASE_MID, i, 1'h0};
      bus_rd <= 1'h1;
      @(posedge core_clk);
      bus_rd <= 1'h0;
      @(posedge core_clk);
      v = bus_rdata;
   endtask
   task automatic rc(input string nm, input logic [4:0] i,
         input logic [31:0] e);
      logic [15:0] v;
      rd(i, v);
      chk(nm, e, {16'h0000, v});
   endtask
   task automatic start(input logic [7:0] t, input logic [7:0] s);
      wr(5'h05, {8'h00, t});
      wr(5'h06, {8'h00, s});
   endtask
   // Waits for the sequence flag, then compares the four or eight result slots it filled
   task automatic finish_run(input logic [7:0] t, input logic [7:0] s);
      logic [15:0] v;
      int n;
      int e;
      v = 16'h0000;
      n = s[4] ? 8 : 4;
      e = t[7] ? level : level >> 2;
      for (int k = 0; k < 3000 && v[15] !== 1'h1; k++)
         rd(5'h07, v);
      chk("status", n == 8 ? 32'h80ff : 32'h800f, v & 16'h80ff);
      for (int i = 0; i < n; i++) begin
         rc("right", 5'h08 + i[4:0], e);
         rc("left", 5'h18 + i[4:0], e << (t[7] ? 6 : 8));
         rc("sgn", 5'h10 + i[4:0], (e << (t[7] ? 6 : 8)) ^ 32'h8000);
      end
   endtask
   initial begin
      #(60000 * 100);
      n_mismatch++;
      end_of_test();
   end
   initial begin
      logic [15:0] v;
      logic [31:0] r;
      logic [7:0] t;
      logic [7:0] s;
      sar_adc_pkg::analog_ctrl_t h;
      pin_in <= $random(seed);
      repeat (3) @(posedge core_clk);
      rst <= 1'h0;
      // Reset values, reserved words and the input port
      rc("cfg", 5'h00, 32'h8000);
      rc("tim", 5'h05, 32'h0003);
      rc("seq", 5'h06, 32'h0000);
      rc("rsv2", 5'h02, 32'h0000);
      rc("rsv4", 5'h04, 32'h0000);
      v = $random(seed);
      wr(5'h01, v);
      rc("test", 5'h01, v);
      wr(5'h03, v);
      rc("port", 5'h03, {v[15:8], pin_in});
      chk("pins", v[15:8], pin_out);
      // Other bank selected: the old bank must not answer
      module_map_select <= 1'h1;
      wr(5'h01, 16'h0000);
      rc("miss", 5'h01, 32'h0000);
      bk = 4'hf;
      rc("bankf", 5'h01, v);
      wr(5'h00, 16'h0000);
      repeat (20) @(posedge core_clk);
      // Every sample length, both lengths, block and scan modes
      for (int k = 0; k < 4; k++) begin
         r = $random(seed);
         level <= r[25:16];
         t = {r[7], k[1:0], 5'h02 + {2'h0, r[2:0]}};
         s = {1'h0, k == 3, k == 2, k[0],
            k < 3 ? 4'hc + k[3:0] : {1'h0, r[10:8]}};
         start(t, s);
         finish_run(t, s);
      end
      // Abort in mid resolve, stay halted, then restart
      start(8'h82, 8'h05);
      repeat (60) @(posedge core_clk);
      wr(5'h05, 16'h0082);
      repeat (200) @(posedge core_clk);
      rd(5'h07, v);
      chk("halt", 32'h0000, {conv_busy, v & 16'h80ff});
      start(8'h82, 8'h05);
      finish_run(8'h82, 8'h05);
      // Each freeze response, then resume
      for (int f = 0; f < 4; f++) begin
         wr(5'h00, {1'h0, f[1:0], 13'h0000});
         start(8'h82, 8'h06);
         repeat (60) @(posedge core_clk);
         freeze <= 1'h1;
         repeat (10) @(posedge core_clk);
         h = actl;
         repeat (390) @(posedge core_clk);
         rd(5'h07, v);
         chk("frz", f == 3 ? 32'h0 : f == 2 ? 32'h1 : 32'h800f,
            v & 16'h80ff);
         if (f == 3)
            chk("hold", h, actl);
         freeze <= 1'h0;
         finish_run(8'h82, 8'h06);
      end
      // Stop mid conversion; registers stay reachable
      start(8'h82, 8'h06);
      repeat (60) @(posedge core_clk);
      wr(5'h00, 16'h8000);
      rc("stoptim", 5'h05, 32'h0082);
      rd(5'h07, v);
      chk("stopped", 32'h0000, {conv_busy, v & 16'h80ff});
      wr(5'h00, 16'h0000);
      rst <= 1'h1;
      repeat (3) @(posedge core_clk);
      rst <= 1'h0;
      rc("cfg2", 5'h00, 32'h8000);
      end_of_test();
   end
endmodule
`default_nettype wire
